// >>> include/ebd_map.vh
// Register map, field positions and reset values of the buffer DMA engine.
`ifndef EBD_MAP_VH
`define EBD_MAP_VH

// ****************************************************************
// Register byte offsets on the Wishbone bus
// ****************************************************************
`define EBD_OFF_IRQ_EN 8'h00
`define EBD_OFF_IRQ_FLAGS 8'h04
`define EBD_OFF_CONTROL 8'h08
`define EBD_OFF_RXST_LO 8'h0C
`define EBD_OFF_RXST_HI 8'h10
`define EBD_OFF_RXND_LO 8'h14
`define EBD_OFF_RXND_HI 8'h18
`define EBD_OFF_SRCF_LO 8'h1C
`define EBD_OFF_SRCF_HI 8'h20
`define EBD_OFF_SRCL_LO 8'h24
`define EBD_OFF_SRCL_HI 8'h28
`define EBD_OFF_DSTF_LO 8'h2C
`define EBD_OFF_DSTF_HI 8'h30
`define EBD_OFF_SUM_LO 8'h34
`define EBD_OFF_SUM_HI 8'h38

// ****************************************************************
// Field positions
// ****************************************************************
`define EBD_BIT_DONE 5
`define EBD_BIT_GO 5
`define EBD_BIT_SUM 4
`define EBD_BIT_TXREQ 3
`define EBD_PTR_W 13
`define EBD_HI_W 5

// ****************************************************************
// Reset values and checksum pad byte
// ****************************************************************
`define EBD_RST_PTR 13'h0000
`define EBD_RST_RXND 13'h1FFF
`define EBD_RST_SUM 16'h0000
`define EBD_PAD_BYTE 8'h00

`endif

// >>> rtl/ebd_dma.v
// Byte-serial copy and checksum engine for the 8-Kbyte packet buffer.
//
// Our own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "ebd_map.vh"

module ebd_dma
(
    // Clock and reset.
    input wire CLK_I,
    input wire RST_I,
    // Wishbone classic slave.
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    output reg [31:0] DAT_O,
    output wire ACK_O,
    // Neighbouring engines of the controller.
    input wire TX_SEND_REQUEST_I,
    input wire RX_WR_REQ_I,
    input wire PORT_ACCESS_I,
    // Buffer memory, read data one cycle after the read strobe.
    output reg [12:0] MEM_RD_ADDR_O,
    output reg MEM_RD_O,
    input wire [7:0] MEM_RDATA_I,
    output reg [12:0] MEM_WR_ADDR_O,
    output reg MEM_WR_O,
    output reg [7:0] MEM_WDATA_O,
    // Completion interrupt request.
    output reg IRQ_O
);

    // ****************************************************************
    // Decoding and arithmetic helpers
    // ****************************************************************

    // Address match, shared by the read mux and the write decode.
    function is_reg;
        input [7:0] adr;
        input [7:0] off;
        begin
            is_reg = (adr[7:2] == off[7:2]);
        end
    endfunction

    // 16-bit one's complement addition with end-around carry.
    function [15:0] oc_add;
        input [15:0] a;
        input [15:0] b;
        reg [16:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            oc_add = s[15:0] + {15'h0000, s[16]};
        end
    endfunction

    localparam ST_IDLE = 3'd0;
    localparam ST_WAIT_TX = 3'd1;
    localparam ST_RUN = 3'd2;
    localparam ST_DRAIN = 3'd3;

    // ****************************************************************
    // Registers
    // ****************************************************************
    reg ack_r;
    reg irq_en_r;
    reg done_flag_r;
    reg go_r;
    reg sum_mode_r;
    reg [12:0] rx_start_r;
    reg [12:0] rx_end_r;
    reg [12:0] src_first_r;
    reg [12:0] src_last_r;
    reg [12:0] dst_first_r;
    reg [15:0] sum_result_r;
    reg [2:0] state_r;
    reg [12:0] src_ptr_r;
    reg [12:0] dst_ptr_r;
    reg [15:0] acc_r;
    reg [7:0] hi_byte_r;
    reg hi_pend_r;
    reg vld_r;
    reg last_r;
    reg rd_vld_r;
    reg rd_last_r;

    wire wb_req = CYC_I & STB_I;
    wire wb_wr = wb_req & WE_I & ack_r & SEL_I[0];
    wire [7:0] wd = DAT_I[7:0];
    wire active = (state_r != ST_IDLE);
    // Firmware data port traffic only steals cycles from a checksum.
    wire stall = RX_WR_REQ_I | (PORT_ACCESS_I & sum_mode_r);
    wire issue = (state_r == ST_RUN) & go_r & ~stall;
    wire at_last = (src_ptr_r == src_last_r);
    wire finish = vld_r & last_r & go_r;
    wire [15:0] word = hi_pend_r ? {hi_byte_r, MEM_RDATA_I}
                                 : {MEM_RDATA_I, `EBD_PAD_BYTE};
    wire [15:0] acc_add = oc_add(acc_r, word);

    // Bus acknowledge is given one cycle after the request, then dropped.
    assign ACK_O = ack_r;

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            ack_r <= 1'b0;
        else
            ack_r <= wb_req & ~ack_r;
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************

    // Writes land at the edge on which the master samples ack high.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            irq_en_r <= 1'b0;
            rx_start_r <= `EBD_RST_PTR;
            rx_end_r <= `EBD_RST_RXND;
            src_first_r <= `EBD_RST_PTR;
            src_last_r <= `EBD_RST_PTR;
            dst_first_r <= `EBD_RST_PTR;
            sum_mode_r <= 1'b0;
        end
        else if (wb_wr)
        begin
            if (is_reg(ADR_I, `EBD_OFF_IRQ_EN))
                irq_en_r <= wd[`EBD_BIT_DONE];
            if (is_reg(ADR_I, `EBD_OFF_CONTROL))
                sum_mode_r <= wd[`EBD_BIT_SUM];
            // Only 13 address bits exist, so no pointer leaves the buffer.
            if (is_reg(ADR_I, `EBD_OFF_RXST_LO))
                rx_start_r[7:0] <= wd;
            if (is_reg(ADR_I, `EBD_OFF_RXST_HI))
                rx_start_r[12:8] <= wd[4:0];
            if (is_reg(ADR_I, `EBD_OFF_RXND_LO))
                rx_end_r[7:0] <= wd;
            if (is_reg(ADR_I, `EBD_OFF_RXND_HI))
                rx_end_r[12:8] <= wd[4:0];
            if (is_reg(ADR_I, `EBD_OFF_SRCF_LO))
                src_first_r[7:0] <= wd;
            if (is_reg(ADR_I, `EBD_OFF_SRCF_HI))
                src_first_r[12:8] <= wd[4:0];
            if (is_reg(ADR_I, `EBD_OFF_SRCL_LO))
                src_last_r[7:0] <= wd;
            if (is_reg(ADR_I, `EBD_OFF_SRCL_HI))
                src_last_r[12:8] <= wd[4:0];
            if (is_reg(ADR_I, `EBD_OFF_DSTF_LO))
                dst_first_r[7:0] <= wd;
            if (is_reg(ADR_I, `EBD_OFF_DSTF_HI))
                dst_first_r[12:8] <= wd[4:0];
        end
    end

    // Go bit: firmware sets or clears it, hardware clears it on finish.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            go_r <= 1'b0;
        else if (wb_wr & is_reg(ADR_I, `EBD_OFF_CONTROL))
            go_r <= wd[`EBD_BIT_GO];
        else if (finish)
            go_r <= 1'b0;
    end

    // Done flag: a finish in the same cycle as a clear keeps it set.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            done_flag_r <= 1'b0;
        else if (finish)
            done_flag_r <= 1'b1;
        else if (wb_wr & is_reg(ADR_I, `EBD_OFF_IRQ_FLAGS))
            done_flag_r <= wd[`EBD_BIT_DONE];
    end

    // Checksum result: the engine stores it, firmware may overwrite it.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            sum_result_r <= `EBD_RST_SUM;
        else if (finish & sum_mode_r)
            sum_result_r <= ~acc_add;
        else if (wb_wr & is_reg(ADR_I, `EBD_OFF_SUM_LO))
            sum_result_r[7:0] <= wd;
        else if (wb_wr & is_reg(ADR_I, `EBD_OFF_SUM_HI))
            sum_result_r[15:8] <= wd;
    end

    // Interrupt request is registered from flag and enable.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            IRQ_O <= 1'b0;
        else
            IRQ_O <= done_flag_r & irq_en_r;
    end

    // ****************************************************************
    // Register reads
    // ****************************************************************

    // Read data is latched with the request; unmapped words read zero.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
            DAT_O <= 32'h00000000;
        else if (wb_req & ~ack_r)
        begin
            DAT_O <= 32'h00000000;
            if (is_reg(ADR_I, `EBD_OFF_IRQ_EN))
                DAT_O[`EBD_BIT_DONE] <= irq_en_r;
            if (is_reg(ADR_I, `EBD_OFF_IRQ_FLAGS))
                DAT_O[`EBD_BIT_DONE] <= done_flag_r;
            if (is_reg(ADR_I, `EBD_OFF_CONTROL))
                DAT_O[5:3] <= {go_r, sum_mode_r, TX_SEND_REQUEST_I};
            if (is_reg(ADR_I, `EBD_OFF_RXST_LO))
                DAT_O[7:0] <= rx_start_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_RXST_HI))
                DAT_O[4:0] <= rx_start_r[12:8];
            if (is_reg(ADR_I, `EBD_OFF_RXND_LO))
                DAT_O[7:0] <= rx_end_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_RXND_HI))
                DAT_O[4:0] <= rx_end_r[12:8];
            if (is_reg(ADR_I, `EBD_OFF_SRCF_LO))
                DAT_O[7:0] <= src_first_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_SRCF_HI))
                DAT_O[4:0] <= src_first_r[12:8];
            if (is_reg(ADR_I, `EBD_OFF_SRCL_LO))
                DAT_O[7:0] <= src_last_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_SRCL_HI))
                DAT_O[4:0] <= src_last_r[12:8];
            if (is_reg(ADR_I, `EBD_OFF_DSTF_LO))
                DAT_O[7:0] <= dst_first_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_DSTF_HI))
                DAT_O[4:0] <= dst_first_r[12:8];
            if (is_reg(ADR_I, `EBD_OFF_SUM_LO))
                DAT_O[7:0] <= sum_result_r[7:0];
            if (is_reg(ADR_I, `EBD_OFF_SUM_HI))
                DAT_O[7:0] <= sum_result_r[15:8];
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************

    // Pointers live only inside the engine, so programmed registers
    // never move and an abort leaves them exactly as written.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_r <= ST_IDLE;
            src_ptr_r <= `EBD_RST_PTR;
            last_r <= 1'b0;
            vld_r <= 1'b0;
            rd_vld_r <= 1'b0;
            rd_last_r <= 1'b0;
        end
        else if (active & ~go_r)
        begin
            state_r <= ST_IDLE;
            vld_r <= 1'b0;
            last_r <= 1'b0;
            rd_vld_r <= 1'b0;
            rd_last_r <= 1'b0;
        end
        else
        begin
            // Read data only arrives one cycle after the strobe, so the
            // byte marks trail the issue by two stages, not one.
            rd_vld_r <= issue;
            rd_last_r <= issue & at_last;
            vld_r <= rd_vld_r;
            last_r <= rd_last_r;
            case (state_r)
                ST_IDLE:
                begin
                    if (go_r)
                    begin
                        src_ptr_r <= src_first_r;
                        state_r <= ST_WAIT_TX;
                    end
                end
                ST_WAIT_TX:
                begin
                    if (~TX_SEND_REQUEST_I)
                        state_r <= ST_RUN;
                end
                ST_RUN:
                begin
                    if (issue)
                    begin
                        if (at_last)
                            state_r <= ST_DRAIN;
                        else if (src_ptr_r == rx_end_r)
                            src_ptr_r <= rx_start_r;
                        else
                            src_ptr_r <= src_ptr_r + 13'h0001;
                    end
                end
                ST_DRAIN:
                begin
                    if (finish)
                        state_r <= ST_IDLE;
                end
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // Buffer read strobe, one byte per granted cycle.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            MEM_RD_O <= 1'b0;
            MEM_RD_ADDR_O <= `EBD_RST_PTR;
        end
        else
        begin
            MEM_RD_O <= 1'b0;
            if (issue)
            begin
                MEM_RD_O <= 1'b1;
                MEM_RD_ADDR_O <= src_ptr_r;
            end
        end
    end

    // ****************************************************************
    // Copy datapath
    // ****************************************************************

    // A write costs one extra stage so its data comes from a flop.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            MEM_WR_O <= 1'b0;
            MEM_WR_ADDR_O <= `EBD_RST_PTR;
            MEM_WDATA_O <= 8'h00;
            dst_ptr_r <= `EBD_RST_PTR;
        end
        else
        begin
            MEM_WR_O <= vld_r & go_r & ~sum_mode_r;
            if (state_r == ST_IDLE)
                dst_ptr_r <= dst_first_r;
            else if (vld_r & go_r & ~sum_mode_r)
            begin
                MEM_WR_ADDR_O <= dst_ptr_r;
                MEM_WDATA_O <= MEM_RDATA_I;
                // Natural 13-bit overflow gives the 8191 to 0 wrap.
                dst_ptr_r <= dst_ptr_r + 13'h0001;
            end
        end
    end

    // ****************************************************************
    // Checksum datapath
    // ****************************************************************

    // Accumulator and pairing state start clean for every operation.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            acc_r <= `EBD_RST_SUM;
            hi_byte_r <= 8'h00;
            hi_pend_r <= 1'b0;
        end
        else if (state_r == ST_IDLE)
        begin
            acc_r <= `EBD_RST_SUM;
            hi_pend_r <= 1'b0;
        end
        else if (vld_r & go_r & sum_mode_r)
        begin
            if (~hi_pend_r)
            begin
                hi_byte_r <= MEM_RDATA_I;
                hi_pend_r <= 1'b1;
            end
            else
            begin
                acc_r <= acc_add;
                hi_pend_r <= 1'b0;
            end
        end
    end

endmodule

// >>> bench/ebd_props.sv
// Port-level concurrent checks for the buffer DMA engine.
`timescale 1ns/1ns
`include "ebd_map.vh"
module ebd_props
(
    // Clock, reset and register bus.
    input wire CLK_I,
    input wire RST_I,
    input wire CYC_I,
    input wire STB_I,
    input wire WE_I,
    input wire [7:0] ADR_I,
    input wire [3:0] SEL_I,
    input wire [31:0] DAT_I,
    input wire [31:0] DAT_O,
    input wire ACK_O,
    // Neighbours and buffer memory.
    input wire TX_SEND_REQUEST_I,
    input wire RX_WR_REQ_I,
    input wire [12:0] MEM_RD_ADDR_O,
    input wire MEM_RD_O,
    input wire [7:0] MEM_RDATA_I,
    input wire [12:0] MEM_WR_ADDR_O,
    input wire MEM_WR_O,
    input wire [7:0] MEM_WDATA_O
);
    reg [12:0] ring_st_r;
    reg [12:0] ring_nd_r;
    wire bus_wr = CYC_I & STB_I & WE_I & ACK_O & SEL_I[0];

    // Shadow of the ring bounds, so the wrap can be predicted here.
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ring_st_r <= 13'h0000;
            ring_nd_r <= 13'h1FFF;
        end
        else if (bus_wr)
        begin
            case (ADR_I)
                `EBD_OFF_RXST_LO: ring_st_r[7:0] <= DAT_I[7:0];
                `EBD_OFF_RXST_HI: ring_st_r[12:8] <= DAT_I[4:0];
                `EBD_OFF_RXND_LO: ring_nd_r[7:0] <= DAT_I[7:0];
                `EBD_OFF_RXND_HI: ring_nd_r[12:8] <= DAT_I[4:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    sequence rd_pair_s;
        MEM_RD_O ##1 MEM_RD_O;
    endsequence
    sequence wr_pair_s;
        MEM_WR_O ##1 MEM_WR_O;
    endsequence

    ack_pulse_a: assert property (ACK_O |=> !ACK_O)
        else $error("ack held longer than one cycle");
    ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("request not acked in one cycle");
    rd_step_a: assert property (rd_pair_s |-> MEM_RD_ADDR_O ==
        (($past(MEM_RD_ADDR_O) == ring_nd_r) ? ring_st_r
        : $past(MEM_RD_ADDR_O) + 13'h0001))
        else $error("source address did not step or wrap");
    wr_step_a: assert property (wr_pair_s |->
        MEM_WR_ADDR_O == $past(MEM_WR_ADDR_O) + 13'h0001)
        else $error("destination address not linear");
    wr_data_a: assert property (MEM_WR_O |-> $past(MEM_RD_O, 2) &&
        MEM_WDATA_O == $past(MEM_RDATA_I))
        else $error("copied byte differs from byte read");
    tx_wait_a: assert property (TX_SEND_REQUEST_I &&
        $past(TX_SEND_REQUEST_I) |-> !MEM_RD_O)
        else $error("buffer read while transmit pending");
    rx_yield_a: assert property (RX_WR_REQ_I |=> !MEM_RD_O)
        else $error("read issued in a receive cycle");
    hi_zero_a: assert property (ACK_O && !WE_I |->
        DAT_O[31:8] == 24'h000000)
        else $error("unused read bits not zero");
endmodule
bind ebd_dma ebd_props u_ebd_props (.CLK_I(CLK_I), .RST_I(RST_I),
    .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I), .ADR_I(ADR_I),
    .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .TX_SEND_REQUEST_I(TX_SEND_REQUEST_I), .RX_WR_REQ_I(RX_WR_REQ_I),
    .MEM_RD_ADDR_O(MEM_RD_ADDR_O), .MEM_RD_O(MEM_RD_O),
    .MEM_RDATA_I(MEM_RDATA_I), .MEM_WR_ADDR_O(MEM_WR_ADDR_O),
    .MEM_WR_O(MEM_WR_O), .MEM_WDATA_O(MEM_WDATA_O));

// >>> bench/tb.sv
// Self-checking bench for the buffer DMA engine.
`timescale 1ns/1ns
`include "ebd_map.vh"
module tb;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0;
    reg [7:0] adr = 8'h00;
    reg [3:0] sel = 4'h0;
    reg [31:0] dat = 32'h00000000;
    reg tx = 1'b0, rxw = 1'b0, pacc = 1'b0;
    reg [7:0] rdata = 8'h00;
    reg [7:0] q;
    reg [7:0] mem [0:8191];
    wire [31:0] dat_o;
    wire [12:0] raddr, waddr;
    wire [7:0] wdata;
    wire ack, rd, wr, irq;
    integer err_total = 0, cmp_count = 0, rd_cnt = 0, wr_cnt = 0;
    integer c0, c1;

    // 100 MHz clock.
    always #5 clk = ~clk;

    ebd_dma u_ebd_dma (.CLK_I(clk), .RST_I(rst), .CYC_I(cyc),
        .STB_I(stb), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
        .DAT_O(dat_o), .ACK_O(ack), .TX_SEND_REQUEST_I(tx),
        .RX_WR_REQ_I(rxw), .PORT_ACCESS_I(pacc), .MEM_RD_ADDR_O(raddr),
        .MEM_RD_O(rd), .MEM_RDATA_I(rdata), .MEM_WR_ADDR_O(waddr),
        .MEM_WR_O(wr), .MEM_WDATA_O(wdata), .IRQ_O(irq));

    // Buffer model; idle read data toggles so stale bytes never pass.
    always @(posedge clk)
    begin
        if (wr)
            mem[waddr] <= wdata;
        wr_cnt <= wr_cnt + wr;
        rd_cnt <= rd_cnt + rd;
        rdata <= rd ? mem[raddr] : ~rdata;
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task close_out;
        begin
            $display("mismatches %0d compares %0d", err_total, cmp_count);
            if (err_total == 0 && cmp_count > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp)
            begin
                err_total = err_total + 1;
                $display("ERROR %0t: saw %h want %h", $time, seen, exp);
            end
        end
    endtask
    task hang;
        begin
            err_total = err_total + 1;
            $display("ERROR %0t: wait ran out", $time);
            close_out;
        end
    endtask
    // One classic cycle; read data lands in q.
    task wb(input [7:0] a, input w, input [7:0] d);
        integer n;
        begin
            @(posedge clk);
            cyc <= 1'b1;
            stb <= 1'b1;
            we <= w;
            adr <= a;
            sel <= 4'h1;
            dat <= {24'h000000, d};
            n = 0;
            @(posedge clk);
            while (ack !== 1'b1 && n < 20)
            begin
                @(posedge clk);
                n = n + 1;
            end
            if (ack !== 1'b1)
                hang;
            q = dat_o[7:0];
            cyc <= 1'b0;
            stb <= 1'b0;
        end
    endtask
    task set3(input [12:0] s, input [12:0] l, input [12:0] d);
        begin
            wb(`EBD_OFF_SRCF_LO, 1'b1, s[7:0]);
            wb(`EBD_OFF_SRCF_HI, 1'b1, {3'h0, s[12:8]});
            wb(`EBD_OFF_SRCL_LO, 1'b1, l[7:0]);
            wb(`EBD_OFF_SRCL_HI, 1'b1, {3'h0, l[12:8]});
            wb(`EBD_OFF_DSTF_LO, 1'b1, d[7:0]);
            wb(`EBD_OFF_DSTF_HI, 1'b1, {3'h0, d[12:8]});
        end
    endtask
    // Restarts keep a gap of more than four cycles after an end.
    task go(input [7:0] c);
        begin
            repeat (5) @(posedge clk);
            wb(`EBD_OFF_CONTROL, 1'b1, c);
        end
    endtask
    task wait_idle;
        integer n;
        begin
            n = 0;
            q = 8'h20;
            while (q[5] !== 1'b0 && n < 100)
            begin
                wb(`EBD_OFF_CONTROL, 1'b0, 8'h00);
                n = n + 1;
            end
            if (q[5] !== 1'b0)
                hang;
        end
    endtask
    task rdchk(input [7:0] a, input [7:0] exp);
        begin
            wb(a, 1'b0, 8'h00);
            chk(q, exp);
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_reset;
        begin
            rdchk(`EBD_OFF_RXND_LO, 8'hFF);
            rdchk(`EBD_OFF_RXND_HI, 8'h1F);
            wb(8'h3C, 1'b1, 8'h5A);
            rdchk(8'h3C, 8'h00);
            rdchk(`EBD_OFF_SUM_HI, 8'h00);
            $display("reset test done");
        end
    endtask
    task t_sum(input [12:0] last, input [15:0] exp);
        begin
            c0 = rd_cnt;
            c1 = wr_cnt;
            set3(13'h0010, last, 13'h0000);
            wb(`EBD_OFF_IRQ_EN, 1'b1, 8'h20);
            wb(`EBD_OFF_IRQ_FLAGS, 1'b1, 8'h00);
            go(8'h30);
            wait_idle;
            rdchk(`EBD_OFF_SUM_LO, exp[7:0]);
            rdchk(`EBD_OFF_SUM_HI, exp[15:8]);
            chk(rd_cnt - c0, last - 13'h000F);
            chk(wr_cnt - c1, 0);
            wb(`EBD_OFF_IRQ_FLAGS, 1'b0, 8'h00);
            chk(q[5], 1'b1);
            chk(irq, 1'b1);
            rdchk(`EBD_OFF_SRCL_LO, last[7:0]);
            $display("checksum test done");
        end
    endtask
    task t_tx;
        begin
            c0 = rd_cnt;
            tx <= 1'b1;
            wb(`EBD_OFF_SRCL_LO, 1'b1, 8'h12);
            go(8'h30);
            repeat (20) @(posedge clk);
            chk(rd_cnt - c0, 0);
            rdchk(`EBD_OFF_CONTROL, 8'h38);
            tx <= 1'b0;
            @(posedge clk);
            pacc <= 1'b1;
            @(posedge clk);
            pacc <= 1'b0;
            wait_idle;
            rdchk(`EBD_OFF_SUM_LO, 8'h53);
            $display("transmit hold test done");
        end
    endtask
    task t_copy;
        begin
            mem[13'h0100] = 8'hA0;
            mem[13'h0101] = 8'hA1;
            mem[13'h0102] = 8'hA2;
            mem[13'h0001] = 8'h55;
            wb(`EBD_OFF_RXST_HI, 1'b1, 8'h01);
            wb(`EBD_OFF_RXND_LO, 1'b1, 8'h02);
            wb(`EBD_OFF_RXND_HI, 1'b1, 8'h01);
            set3(13'h0101, 13'h0100, 13'h1FFE);
            wb(`EBD_OFF_IRQ_EN, 1'b1, 8'h00);
            wb(`EBD_OFF_IRQ_FLAGS, 1'b1, 8'h00);
            go(8'h20);
            repeat (2) @(posedge clk);
            rxw <= 1'b1;
            @(posedge clk);
            rxw <= 1'b0;
            wait_idle;
            repeat (3) @(posedge clk);
            chk(mem[13'h1FFE], 8'hA1);
            chk(mem[13'h1FFF], 8'hA2);
            chk(mem[13'h0000], 8'hA0);
            chk(mem[13'h0001], 8'h55);
            wb(`EBD_OFF_IRQ_FLAGS, 1'b0, 8'h00);
            chk(q[5], 1'b1);
            chk(irq, 1'b0);
            rdchk(`EBD_OFF_SUM_LO, 8'h53);
            $display("copy test done");
        end
    endtask
    task t_abort;
        begin
            set3(13'h0200, 13'h01FF, 13'h0800);
            wb(`EBD_OFF_IRQ_FLAGS, 1'b1, 8'h00);
            go(8'h20);
            repeat (8) @(posedge clk);
            wb(`EBD_OFF_CONTROL, 1'b1, 8'h00);
            repeat (2) @(posedge clk);
            c1 = wr_cnt;
            repeat (6) @(posedge clk);
            chk(wr_cnt - c1, 0);
            rdchk(`EBD_OFF_IRQ_FLAGS, 8'h00);
            rdchk(`EBD_OFF_SUM_HI, 8'hA9);
            rdchk(`EBD_OFF_SRCF_HI, 8'h02);
            $display("abort test done");
        end
    endtask

    // Main sequence.
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_reset;
        mem[13'h0010] = 8'h89;
        mem[13'h0011] = 8'hAB;
        mem[13'h0012] = 8'hCD;
        t_sum(13'h0012, 16'hA953);
        t_sum(13'h0011, 16'h7654);
        t_tx;
        t_copy;
        t_abort;
        close_out;
    end
endmodule
